// *** pio_pkg.sv ***
package pio_pkg;

	// ==========================================================
	// Clocking
	// System clock rate and the master tick for the clock dividers
	localparam longint SYS_CLK_HZ = 64'd100_000_000;
	// Master tick is twice the option slot clock
	localparam longint MASTER_TICK_HZ = 64'd6_144_000;
	// Phase accumulator width of the master tick generator
	localparam int NCO_W = 24;
	// Accumulator increment derived from the two rates
	localparam logic [NCO_W-1:0] NCO_INC =
		NCO_W'((MASTER_TICK_HZ * (64'd1 << NCO_W)) / SYS_CLK_HZ);
	// Display clock phases per period, the last one is high
	localparam logic [1:0] DISP_PHASES = 2'h3;
	// Display clock edges per debouncer tick (1.024 MHz to 128 kHz)
	localparam logic [2:0] DEB_DIV_LAST = 3'h7;
	// Debouncer ticks per key scan tick (128 kHz to 4 kHz)
	localparam logic [4:0] KEY_DIV_LAST = 5'h1f;

	// ==========================================================
	// Times
	localparam int DEB_TICK_HZ = 128_000;
	localparam int KEY_TICK_HZ = 4_000;
	// Least stable time of a key change, in microseconds
	localparam int KEY_STABLE_US = 16_000;
	// Least stable time of the count input, in microseconds
	localparam int TOT_STABLE_US = 1_750;
	// Number of driven key columns, one per scan tick
	localparam int KEY_COLS = 3;
	// Number of sensed key rows
	localparam int KEY_ROWS = 3;
	// Full scans needed for the key stable time, rounded up
	localparam int KEY_STABLE_SCANS =
		(KEY_STABLE_US * KEY_TICK_HZ + KEY_COLS * 1_000_000 - 1) / (KEY_COLS * 1_000_000);
	// Debouncer ticks needed for the count stable time, rounded up
	localparam int TOT_STABLE_TICKS =
		(TOT_STABLE_US * DEB_TICK_HZ + 1_000_000 - 1) / 1_000_000;

	// ==========================================================
	// Register index on address bits 6..3
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ALARM = 4'h1;
	localparam logic [3:0] REG_DOUT = 4'h2;
	localparam logic [3:0] REG_DIN = 4'h3;
	localparam logic [3:0] REG_KEY = 4'h4;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [3:0] ALARM_RST = 4'h0;
	localparam logic [7:0] DOUT_RST = 8'h00;
	// Status bit positions in the control/status read value
	localparam int STAT_KEY_IRQ = 4;
	localparam int STAT_TRIG_LVL = 5;
	// Key register fields
	localparam int KEY_PRESSED_BIT = 7;

	// ==========================================================
	// Configuration load
	// Mode pin pattern for host driven peripheral load
	localparam logic [2:0] MODE_PERIPHERAL = 3'h5;
	// Default configuration length in bytes
	localparam int CFG_BYTES_DEF = 16;
	// Busy count loaded per byte; the ready output stays low one cycle longer, 5 cycles
	localparam logic [3:0] CFG_BUSY_CYC = 4'h4;

	// Control register layout, low nibble of register 0
	typedef struct packed {
		logic [3:0] spare;
		logic trig_level;
		logic trig_enable;
		logic tot_debounce_en;
		logic key_scan_en;
	} pio_ctrl_type;

	// Host bus strobes and address as one group
	typedef struct packed {
		logic chip_select_n;
		logic read_n;
		logic write_n;
		logic [3:0] index;
		logic [7:0] wdata;
	} pio_bus_type;

	// Configuration sequencer, Gray coded along the path
	typedef enum logic [1:0] {
		CFG_CLEAR = 2'b00,
		CFG_MODE = 2'b01,
		CFG_LOAD = 2'b11,
		CFG_RUN = 2'b10
	} pio_cfg_type;

endpackage

// *** pio_clk_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module pio_clk_gen (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	output logic opt_clk,
	output logic disp_clk,
	output logic deb_tick,
	output logic key_tick
);

	// ==========================================================
	// Master tick
	logic [pio_pkg::NCO_W:0] acc_r; // Accumulator with carry bit
	logic [1:0] phase_r; // Display clock phase
	logic [2:0] deb_cnt_r; // Display edges toward debouncer tick
	logic [4:0] key_cnt_r; // Debouncer ticks toward key tick
	logic master;

	// Carry out marks one master tick
	assign master = acc_r[pio_pkg::NCO_W];

	// Phase accumulator for the fractional divide
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			acc_r <= '0;
		end else if (ce) begin
			acc_r <= {1'b0, acc_r[pio_pkg::NCO_W-1:0]} + {1'b0, pio_pkg::NCO_INC};
		end
	end

	// ==========================================================
	// Option and display clocks
	// Option clock toggles on every master tick
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			opt_clk <= 1'b0;
		end else if (ce && master) begin
			opt_clk <= ~opt_clk;
		end
	end

	// Display clock high in last of three option periods
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			phase_r <= 2'h0;
			disp_clk <= 1'b0;
		end else if (ce && master && !opt_clk) begin
			if (phase_r == pio_pkg::DISP_PHASES - 2'h1) begin
				phase_r <= 2'h0;
				disp_clk <= 1'b0;
			end else begin
				phase_r <= phase_r + 2'h1;
				disp_clk <= (phase_r == pio_pkg::DISP_PHASES - 2'h2);
			end
		end
	end

	// ==========================================================
	// Internal ticks from display clock rising edges
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			deb_cnt_r <= 3'h0;
			key_cnt_r <= 5'h0;
			deb_tick <= 1'b0;
			key_tick <= 1'b0;
		end else if (ce) begin
			deb_tick <= 1'b0;
			key_tick <= 1'b0;
			if (master && !opt_clk && phase_r == pio_pkg::DISP_PHASES - 2'h2) begin
				deb_cnt_r <= deb_cnt_r + 3'h1;
				if (deb_cnt_r == pio_pkg::DEB_DIV_LAST) begin
					deb_tick <= 1'b1;
					key_cnt_r <= key_cnt_r + 5'h1;
					key_tick <= (key_cnt_r == pio_pkg::KEY_DIV_LAST);
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** pio_stable_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module pio_stable_filter #(
	parameter int WIDTH = 1,
	parameter int STABLE = 2,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic tick,
	input wire logic [WIDTH-1:0] sample,
	output logic [WIDTH-1:0] settled,
	output logic changed
);

	// ==========================================================
	// Stability counter
	logic [WIDTH-1:0] last_r; // Sample of the previous tick
	logic [7:0] cnt_r; // Ticks the new value has stood

	// Count ticks while a differing sample holds still
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			last_r <= INIT;
			cnt_r <= 8'h00;
			settled <= INIT;
			changed <= 1'b0;
		end else if (ce) begin
			changed <= 1'b0;
			if (tick) begin
				last_r <= sample;
				if (sample == settled || sample != last_r) begin
					// Restart when equal to output or still moving
					cnt_r <= 8'h00;
				end else if (cnt_r == 8'(STABLE - 2)) begin
					// Stable for the full time, take it
					cnt_r <= 8'h00;
					settled <= sample;
					changed <= 1'b1;
				end else begin
					cnt_r <= cnt_r + 8'h01;
				end
			end
		end
	end

endmodule

`default_nettype wire

// *** pio_top.sv ***
// Functional notes
// - Derive option and display clocks from system clock
// - Display clock low two thirds, high one third
// - Divide display clock to 128 kHz, 4 kHz
// - Decode address bits 3-6 with select, strobes
// - Five readable, three writable registers
// - Scan key matrix on six pulled-up lines
// - Accept key change after 16 ms stable
// - Key interrupt active low, halts scanning
// - Reading key register clears interrupt, resumes scan
// - Interrupt on every debounced key change
// - Control bit enables or disables key scanning
// - Writable, readable digital and alarm output registers
// - Digital input buffer returns current levels
// - Count input optionally passes through debouncer
// - Trigger interrupt on selectable input level
// - After reset sample mode pins, enter loading
// - Raise init status when ready for bytes
// - Ready low while absorbing each byte
// - Hold done low while loading, then release
// - Count debouncer needs 1.75 ms stable input
// - Host alternates trigger level for both edges
`timescale 1ns/1ps
`default_nettype none

module pio_top #(
	parameter int CFG_BYTES = pio_pkg::CFG_BYTES_DEF
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic logic_chip_select_n,
	input wire logic upper_byte_read_n,
	input wire logic upper_byte_write_n,
	input wire logic [3:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rdata_oe,
	input wire logic [2:0] mode_pins,
	output logic config_init_status,
	output logic config_byte_ready,
	input wire logic config_done_line_in,
	output logic config_done_line_out,
	output logic config_done_line_oe,
	output logic option_slot_clock_out,
	output logic display_clock_out,
	input wire logic [5:0] key_matrix_line_in,
	output logic [5:0] key_matrix_line_out,
	output logic [5:0] key_matrix_line_oe,
	output logic key_event_irq_n,
	output logic [7:0] digital_out_bits,
	output logic [3:0] alarm_out_bits,
	input wire logic [7:0] digital_in_bits,
	input wire logic count_input_n,
	output logic count_output,
	input wire logic ext_trigger_in,
	output logic ext_trigger_irq_n
);

	// ==========================================================
	// Declarations
	localparam int KEYS = pio_pkg::KEY_COLS * pio_pkg::KEY_ROWS;
	pio_pkg::pio_bus_type bus; // Host bus as one group
	pio_pkg::pio_bus_type bus_prev_r; // Bus of the previous cycle
	pio_pkg::pio_ctrl_type ctrl_r; // Control register
	pio_pkg::pio_cfg_type cfg_r; // Configuration sequencer
	logic [7:0] cfg_cnt_r; // Configuration bytes taken
	logic [3:0] busy_r; // Cycles left absorbing a byte
	logic [7:0] dout_r; // Digital output register
	logic [3:0] alarm_r; // Alarm output register
	logic [1:0] col_r; // Driven column
	logic [KEYS-1:0] snap_r; // Keys seen in the current scan
	logic [KEYS-1:0] frame_r; // Last complete scan
	logic frame_tick_r; // One complete scan done
	logic [KEYS-1:0] keys; // Debounced key state
	logic key_change; // Debounced key change pulse
	logic key_irq_r; // Key interrupt pending
	logic tot_settled; // Debounced count input
	logic opt_clk, disp_clk, deb_tick, key_tick;
	logic run, wr_edge, rd_edge, scan_go;
	logic [7:0] key_code;

	// Synchronous host strobes as one group
	assign bus = '{chip_select_n: logic_chip_select_n, read_n: upper_byte_read_n,
		write_n: upper_byte_write_n, index: host_addr, wdata: host_wdata};
	assign run = (cfg_r == pio_pkg::CFG_RUN);
	// Write taken as the strobe returns high
	assign wr_edge = !bus_prev_r.chip_select_n && !bus_prev_r.write_n && bus.write_n;
	// Read effect once, on the strobe's fall
	assign rd_edge = !bus.chip_select_n && !bus.read_n && bus_prev_r.read_n;
	// Scan only when enabled and no key event pending
	assign scan_go = run && ctrl_r.key_scan_en && !key_irq_r;

	// ==========================================================
	// Submodules
	// Clock dividers
	pio_clk_gen u_clk (
		.sys_clk(sys_clk),
		.reset(reset),
		.ce(ce),
		.opt_clk(opt_clk),
		.disp_clk(disp_clk),
		.deb_tick(deb_tick),
		.key_tick(key_tick)
	);

	// Key debouncer, stepped once per complete scan
	pio_stable_filter #(
		.WIDTH(KEYS),
		.STABLE(pio_pkg::KEY_STABLE_SCANS)
	) u_key_filter (
		.sys_clk(sys_clk),
		.reset(reset),
		.ce(ce),
		.tick(frame_tick_r),
		.sample(frame_r),
		.settled(keys),
		.changed(key_change)
	);

	// Count input debouncer, active high sense of the input
	pio_stable_filter #(
		.WIDTH(1),
		.STABLE(pio_pkg::TOT_STABLE_TICKS)
	) u_tot_filter (
		.sys_clk(sys_clk),
		.reset(reset),
		.ce(ce),
		.tick(deb_tick),
		.sample(~count_input_n),
		.settled(tot_settled),
		.changed()
	);

	// ==========================================================
	// Bus history for strobe edges
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bus_prev_r <= '{chip_select_n: 1'b1, read_n: 1'b1, write_n: 1'b1,
				index: 4'h0, wdata: 8'h00};
		end else if (ce) begin
			bus_prev_r <= bus;
		end
	end

	// ==========================================================
	// Configuration sequencer
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cfg_r <= pio_pkg::CFG_CLEAR;
			cfg_cnt_r <= 8'h00;
			busy_r <= 4'h0;
		end else if (ce) begin
			case (cfg_r)
				pio_pkg::CFG_CLEAR: begin
					// Memory clear once reset is gone
					cfg_cnt_r <= 8'h00;
					cfg_r <= pio_pkg::CFG_MODE;
				end
				pio_pkg::CFG_MODE: begin
					// Only the peripheral pattern enters loading
					if (mode_pins == pio_pkg::MODE_PERIPHERAL) begin
						cfg_r <= pio_pkg::CFG_LOAD;
					end
				end
				pio_pkg::CFG_LOAD: begin
					if (busy_r != 4'h0) begin
						busy_r <= busy_r - 4'h1;
					end else if (cfg_cnt_r == 8'(CFG_BYTES)) begin
						cfg_r <= pio_pkg::CFG_RUN;
					end else if (wr_edge) begin
						// Absorb one byte, ready low meanwhile
						cfg_cnt_r <= cfg_cnt_r + 8'h01;
						busy_r <= pio_pkg::CFG_BUSY_CYC;
					end
				end
				default: begin
					cfg_r <= pio_pkg::CFG_RUN;
				end
			endcase
		end
	end

	// Load status pins, done line is open drain
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			config_init_status <= 1'b0;
			config_byte_ready <= 1'b1;
			config_done_line_out <= 1'b0;
			config_done_line_oe <= 1'b1;
		end else if (ce) begin
			config_init_status <= (cfg_r == pio_pkg::CFG_LOAD) || run;
			config_byte_ready <= !(cfg_r == pio_pkg::CFG_LOAD && (busy_r != 4'h0 || wr_edge));
			config_done_line_out <= 1'b0;
			config_done_line_oe <= !run;
		end
	end

	// ==========================================================
	// Writable registers
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_r <= pio_pkg::CTRL_RST;
			alarm_r <= pio_pkg::ALARM_RST;
			dout_r <= pio_pkg::DOUT_RST;
		end else if (ce && run && wr_edge) begin
			if (bus_prev_r.index == pio_pkg::REG_CTRL) begin
				ctrl_r <= {4'h0, bus_prev_r.wdata[3:0]};
			end else if (bus_prev_r.index == pio_pkg::REG_ALARM) begin
				alarm_r <= bus_prev_r.wdata[3:0];
			end else if (bus_prev_r.index == pio_pkg::REG_DOUT) begin
				dout_r <= bus_prev_r.wdata;
			end
		end
	end

	// Lowest pressed key; top bit flags any key
	always_comb begin
		key_code = 8'h00;
		for (int i = KEYS - 1; i >= 0; i--) begin
			if (keys[i]) begin
				key_code = 8'h80 | 8'(i);
			end
		end
	end

	// ==========================================================
	// Read data while select and read strobe are low
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			host_rdata <= 8'h00;
			host_rdata_oe <= 1'b0;
		end else if (ce) begin
			host_rdata_oe <= run && !bus.chip_select_n && !bus.read_n;
			if (bus.index == pio_pkg::REG_CTRL) begin
				host_rdata <= {2'h0, ext_trigger_in, key_irq_r, ctrl_r[3:0]};
			end else if (bus.index == pio_pkg::REG_ALARM) begin
				host_rdata <= {4'h0, alarm_r};
			end else if (bus.index == pio_pkg::REG_DOUT) begin
				host_rdata <= dout_r;
			end else if (bus.index == pio_pkg::REG_DIN) begin
				host_rdata <= digital_in_bits;
			end else if (bus.index == pio_pkg::REG_KEY) begin
				host_rdata <= key_code;
			end else begin
				host_rdata <= 8'h00;
			end
		end
	end

	// ==========================================================
	// Key scanner: columns 0-2 driven low in turn, rows on 3-5
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			col_r <= 2'h0;
			snap_r <= '0;
			frame_r <= '0;
			frame_tick_r <= 1'b0;
		end else if (ce) begin
			frame_tick_r <= 1'b0;
			if (scan_go && key_tick) begin
				// Closed key pulls its row low against the pull-up
				snap_r[col_r*pio_pkg::KEY_ROWS +: pio_pkg::KEY_ROWS] <= ~key_matrix_line_in[5:3];
				if (col_r == 2'(pio_pkg::KEY_COLS - 1)) begin
					col_r <= 2'h0;
					frame_r <= {~key_matrix_line_in[5:3],
						snap_r[KEYS-pio_pkg::KEY_ROWS-1:0]};
					frame_tick_r <= 1'b1;
				end else begin
					col_r <= col_r + 2'h1;
				end
			end
		end
	end

	// Column drive, released while scanning is stopped
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			key_matrix_line_out <= 6'h00;
			key_matrix_line_oe <= 6'h00;
		end else if (ce) begin
			key_matrix_line_out <= 6'h00;
			key_matrix_line_oe <= scan_go ? {3'h0, 3'(3'h1 << col_r)} : 6'h00;
		end
	end

	// Key interrupt: set by a change, cleared by a key read
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			key_irq_r <= 1'b0;
			key_event_irq_n <= 1'b1;
		end else if (ce) begin
			if (key_change) begin
				key_irq_r <= 1'b1;
			end else if (run && rd_edge && bus.index == pio_pkg::REG_KEY) begin
				key_irq_r <= 1'b0;
			end
			key_event_irq_n <= !(key_change || (key_irq_r &&
				!(run && rd_edge && bus.index == pio_pkg::REG_KEY)));
		end
	end

	// ==========================================================
	// Clock outputs, count path and trigger interrupt
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			option_slot_clock_out <= 1'b0;
			display_clock_out <= 1'b0;
			count_output <= 1'b0;
			ext_trigger_irq_n <= 1'b1;
			digital_out_bits <= pio_pkg::DOUT_RST;
			alarm_out_bits <= pio_pkg::ALARM_RST;
		end else if (ce) begin
			option_slot_clock_out <= opt_clk;
			display_clock_out <= disp_clk;
			// Debounced or raw count input
			count_output <= ctrl_r.tot_debounce_en ? tot_settled : ~count_input_n;
			// Selected input level asserts the trigger interrupt
			ext_trigger_irq_n <= !(run && ctrl_r.trig_enable &&
				ext_trigger_in == ctrl_r.trig_level);
			digital_out_bits <= dout_r;
			alarm_out_bits <= alarm_r;
		end
	end

endmodule

`default_nettype wire

// *** pio_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module pio_checker (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic logic_chip_select_n,
	input wire logic upper_byte_read_n,
	input wire logic upper_byte_write_n,
	input wire logic host_rdata_oe,
	input wire logic config_init_status,
	input wire logic config_byte_ready,
	input wire logic config_done_line_oe,
	input wire logic option_slot_clock_out,
	input wire logic display_clock_out,
	input wire logic [5:0] key_matrix_line_oe,
	input wire logic key_event_irq_n,
	input wire logic [7:0] digital_out_bits
);
	// ======
	// Run lengths of the derived clocks
	logic opt_prev_r, disp_prev_r, seen_r;
	logic [7:0] opt_cnt_r, disp_cnt_r;
	wire logic opt_edge = opt_prev_r != option_slot_clock_out;
	wire logic disp_edge = disp_prev_r != display_clock_out;
	// Level run lengths; seen_r skips the first period
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			opt_prev_r <= 1'b0;
			disp_prev_r <= 1'b0;
			opt_cnt_r <= 8'h00;
			disp_cnt_r <= 8'h00;
			seen_r <= 1'b0;
		end else begin
			opt_prev_r <= option_slot_clock_out;
			disp_prev_r <= display_clock_out;
			opt_cnt_r <= opt_edge ? 8'h01 : opt_cnt_r + 8'h01;
			disp_cnt_r <= disp_edge ? 8'h01 : disp_cnt_r + 8'h01;
			seen_r <= seen_r | (disp_edge & disp_prev_r);
		end
	end
	// ======
	// Properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// Byte write edge while loading
	sequence take_s;
		config_init_status && config_done_line_oe && config_byte_ready &&
			!logic_chip_select_n && !upper_byte_write_n ##1
			!logic_chip_select_n && upper_byte_write_n;
	endsequence
	// Busy window of one byte
	sequence busy_s;
		(!config_byte_ready) [*5] ##1 config_byte_ready;
	endsequence
	opt_run_a: assert property (seen_r && opt_edge |-> opt_cnt_r inside {[15:18]})
		else $error("option half period");
	disp_high_a: assert property (seen_r && disp_edge && disp_prev_r |-> disp_cnt_r inside {[31:35]})
		else $error("display high time");
	disp_low_a: assert property (seen_r && disp_edge && !disp_prev_r |-> disp_cnt_r inside {[63:67]})
		else $error("display low time");
	scan_onehot_a: assert property ($onehot0(key_matrix_line_oe))
		else $error("several columns driven");
	scan_halt_a: assert property (!key_event_irq_n [*3] |-> key_matrix_line_oe == 6'h00)
		else $error("scan during key irq");
	key_clear_a: assert property ($rose(key_event_irq_n) |-> !$past(upper_byte_read_n, 1) || !$past(upper_byte_read_n, 2))
		else $error("irq cleared without read");
	byte_take_a: assert property (take_s |=> !config_byte_ready)
		else $error("byte not taken");
	busy_len_a: assert property ($fell(config_byte_ready) |-> busy_s)
		else $error("busy length");
	done_hold_a: assert property (!config_done_line_oe |=> !config_done_line_oe)
		else $error("done pulled again");
	init_first_a: assert property (!config_byte_ready |-> config_init_status)
		else $error("busy before init");
	rd_strobe_a: assert property (host_rdata_oe |-> !$past(logic_chip_select_n) && !$past(upper_byte_read_n))
		else $error("read data without strobe");
	dout_write_a: assert property ($changed(digital_out_bits) |-> !$past(upper_byte_write_n, 2) || !$past(upper_byte_write_n, 3))
		else $error("outputs changed unwritten");
endmodule
bind pio_top pio_checker chk (.sys_clk, .reset, .logic_chip_select_n, .upper_byte_read_n,
	.upper_byte_write_n, .host_rdata_oe, .config_init_status, .config_byte_ready,
	.config_done_line_oe, .option_slot_clock_out, .display_clock_out, .key_matrix_line_oe,
	.key_event_irq_n, .digital_out_bits);
`default_nettype wire

// *** pio_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pio_host_model #(
	parameter int CFG_BYTES = 2
) (
	input wire logic sys_clk,
	output logic reset,
	output var pio_pkg::pio_bus_type bus,
	output logic done_pull,
	input wire logic [7:0] rdata,
	input wire logic rdata_oe,
	input wire logic init,
	input wire logic ready,
	input wire logic done_line,
	output logic rd_done,
	output logic [8:0] rd_val
);
	// Idle bus, reset held at power up
	initial begin
		reset = 1'b1;
		bus = 15'h7000;
		done_pull = 1'b0;
		rd_done = 1'b0;
		rd_val = 9'h000;
	end
	// Waits up to 60 cycles for a level on init, ready or done
	task automatic wait_on(input int sel, input logic v, inout bit ok);
		bit got = 1'b0;
		for (int n = 0; n < 60 && !got; n++) begin
			got = ((sel == 0) ? init : (sel == 1) ? ready : done_line) === v;
			if (!got) begin
				@(posedge sys_clk);
				#1;
			end
		end
		ok &= got;
	endtask
	// Strobe low one cycle, write taken on its rise
	task automatic bus_wr(input logic [3:0] idx, input logic [7:0] d);
		@(posedge sys_clk);
		#1 bus = {3'b010, idx, d};
		@(posedge sys_clk);
		#1 bus.write_n = 1'b1;
		@(posedge sys_clk);
		#1 bus.chip_select_n = 1'b1;
	endtask
	// Data taken two edges after the strobe falls
	task automatic bus_rd(input logic [3:0] idx);
		@(posedge sys_clk);
		#1 bus = {3'b001, idx, 8'h00};
		repeat (2) @(posedge sys_clk);
		#1 rd_val = {rdata_oe, rdata};
		bus = {3'b111, idx, 8'h00};
		rd_done = 1'b1;
		@(posedge sys_clk);
		#1 rd_done = 1'b0;
	endtask
	// Full load: done low, reset pulse, bytes paced by ready
	task automatic cfg_load(input int rst_cyc, output bit ok);
		ok = 1'b1;
		done_pull = 1'b1;
		reset = 1'b1;
		repeat (rst_cyc) @(posedge sys_clk);
		#1 reset = 1'b0;
		wait_on(0, 1'b1, ok);
		done_pull = 1'b0;
		for (int b = 0; b < CFG_BYTES; b++) begin
			wait_on(1, 1'b1, ok);
			bus_wr(4'h0, 8'(b));
			wait_on(1, 1'b0, ok);
		end
		wait_on(2, 1'b1, ok);
	endtask
endmodule
`default_nettype wire

// *** tb_instrument_io_peripheral_logic.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_instrument_io_peripheral_logic;
	localparam int NB = 2;
	logic sys_clk = 1'b0;
	wire logic reset;
	pio_pkg::pio_bus_type bus;
	logic [2:0] mode_pins = 3'h5;
	logic [7:0] digital_in_bits = 8'h00;
	logic count_input_n = 1'b1;
	logic ext_trigger_in = 1'b0;
	logic key_down = 1'b0;
	wire logic [7:0] host_rdata, digital_out_bits;
	wire logic [5:0] key_matrix_line_out, key_matrix_line_oe, key_matrix_line_in;
	wire logic [3:0] alarm_out_bits;
	wire logic host_rdata_oe, config_init_status, config_byte_ready, config_done_line_out;
	wire logic config_done_line_oe, option_slot_clock_out, display_clock_out, key_event_irq_n;
	wire logic count_output, ext_trigger_irq_n, done_pull, rd_done;
	wire logic [8:0] rd_val;
	// Pulled-up done and matrix lines; one key at column 0, row 0
	wire logic config_done_line_in = !(config_done_line_oe && !config_done_line_out) && !done_pull;
	wire logic [5:0] col_low = key_matrix_line_oe & ~key_matrix_line_out;
	assign key_matrix_line_in = ~(col_low | {2'b00, key_down & col_low[0], 3'b000});
	int err_total = 0;
	int checks = 0;
	logic [8:0] exp_q[$];
	logic [7:0] seed = 8'h37;
	always #5 sys_clk = ~sys_clk;
	pio_top #(.CFG_BYTES(NB)) dut (.sys_clk, .reset, .ce(1'b1),
		.logic_chip_select_n(bus.chip_select_n), .upper_byte_read_n(bus.read_n),
		.upper_byte_write_n(bus.write_n), .host_addr(bus.index), .host_wdata(bus.wdata),
		.host_rdata, .host_rdata_oe, .mode_pins, .config_init_status, .config_byte_ready,
		.config_done_line_in, .config_done_line_out, .config_done_line_oe,
		.option_slot_clock_out, .display_clock_out, .key_matrix_line_in,
		.key_matrix_line_out, .key_matrix_line_oe, .key_event_irq_n, .digital_out_bits,
		.alarm_out_bits, .digital_in_bits, .count_input_n, .count_output,
		.ext_trigger_in, .ext_trigger_irq_n);
	pio_host_model #(.CFG_BYTES(NB)) host (.sys_clk, .reset, .bus, .done_pull,
		.rdata(host_rdata), .rdata_oe(host_rdata_oe), .init(config_init_status),
		.ready(config_byte_ready), .done_line(config_done_line_in), .rd_done, .rd_val);
	// ======
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic fail(input string m);
		$display("[FAIL] %0t %s", $time, m);
		err_total++;
	endtask
	task automatic chk(input logic c, input string m);
		checks++;
		if (c !== 1'b1)
			fail(m);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Note expected {oe, data}, then read
	task automatic rd(input logic [3:0] i, input logic [8:0] e);
		exp_q.push_back(e);
		host.bus_rd(i);
	endtask
	// Compare each read with the oldest note
	always @(posedge sys_clk) begin
		if (rd_done === 1'b1) begin
			checks++;
			if (exp_q.size() == 0 || rd_val !== exp_q.pop_front())
				fail("read value mismatch");
		end
	end
	task automatic results();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#1_000_000;
		fail("watchdog expired");
		results();
	end
	// ======
	// Main sequence
	initial begin
		bit ok;
		logic [7:0] v;
		int nd, no;
		logic pd, po;
		fork
			host.cfg_load(2, ok);
			begin
				#12 chk(!config_init_status && config_byte_ready, "reset state");
				chk(config_done_line_oe && key_event_irq_n, "reset outputs");
			end
		join
		if (!ok)
			host.cfg_load(1000, ok);
		chk(ok && !config_done_line_oe, "configuration load");
		for (int k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			host.bus_wr(pio_pkg::REG_DOUT, seed);
			host.bus_wr(pio_pkg::REG_ALARM, ~seed);
			digital_in_bits = seed ^ 8'h5a;
			wait_cyc(2);
			chk(digital_out_bits === seed && alarm_out_bits === ~seed[3:0], "output pins");
			rd(pio_pkg::REG_DOUT, {1'b1, seed});
			rd(pio_pkg::REG_ALARM, {5'h10, ~seed[3:0]});
			rd(pio_pkg::REG_DIN, {1'b1, seed ^ 8'h5a});
		end
		host.bus_wr(4'h7, 8'h00);
		host.bus_wr(pio_pkg::REG_DIN, 8'hff);
		rd(4'h7, 9'h100);
		rd(pio_pkg::REG_DOUT, {1'b1, seed});
		rd(pio_pkg::REG_DIN, {1'b1, seed ^ 8'h5a});
		rd(pio_pkg::REG_KEY, 9'h100);
		for (int k = 0; k < 8; k++) begin
			host.bus_wr(pio_pkg::REG_CTRL, {4'h0, k[1], k[2], 2'b00});
			ext_trigger_in = k[0];
			wait_cyc(3);
			chk(ext_trigger_irq_n === !(k[2] && k[0] == k[1]), "trigger interrupt");
			rd(pio_pkg::REG_CTRL, {3'b100, k[0], 1'b0, k[1], k[2], 2'b00});
		end
		for (int k = 0; k < 2; k++) begin
			count_input_n = k[0];
			wait_cyc(3);
			chk(count_output === !k[0], "count bypass");
		end
		host.bus_wr(pio_pkg::REG_CTRL, 8'h02);
		wait_cyc(3);
		v[0] = count_output;
		count_input_n = 1'b0;
		wait_cyc(100);
		count_input_n = 1'b1;
		wait_cyc(3);
		chk(count_output === v[0], "count glitch passed");
		host.bus_wr(pio_pkg::REG_CTRL, 8'h01);
		key_down = 1'b1;
		wait_cyc(30);
		chk(key_matrix_line_oe inside {6'h01, 6'h02, 6'h04}, "scan column");
		nd = 0;
		no = 0;
		for (int n = 0; n < 977; n++) begin
			pd = display_clock_out;
			po = option_slot_clock_out;
			wait_cyc(1);
			nd += int'(display_clock_out && !pd);
			no += int'(option_slot_clock_out && !po);
		end
		chk(nd inside {[9:11]}, "display clock rate");
		chk(no inside {[29:31]}, "option clock rate");
		wait_cyc(29000);
		chk(key_event_irq_n, "key accepted early");
		host.bus_wr(pio_pkg::REG_CTRL, 8'h00);
		wait_cyc(3);
		chk(!key_matrix_line_oe, "scan not stopped");
		host.cfg_load(1000, ok);
		if (!ok)
			host.cfg_load(1000, ok);
		chk(ok, "reload");
		rd(pio_pkg::REG_DOUT, 9'h100);
		results();
	end
endmodule
`default_nettype wire
